// [verilog/tch_dev.sv]
// Purpose: touch controller bus slave, reset sequencing, modes and interrupt
// Assumes: 20 MHz core clock; touch and gesture events come from the scanner
// Notes:   rst_in stands for the internal power-on reset
`timescale 1ns/1ps

module tch_dev #(
	parameter int INIT_CYC    = tch_pkg::INIT_CYC,
	parameter int STANDBY_CYC = tch_pkg::STANDBY_CYC
) (
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic       touch_valid_in,
	input  wire logic [7:0] touch_x_in,
	input  wire logic [7:0] touch_y_in,
	input  wire logic       gesture_in,
	input  wire logic [7:0] gesture_id_in,
	output logic      [1:0] mode_out,
	output logic            scan_en_out,
	output logic            ready_out,
	tch_if.dev              link
);
	logic [1:0] scl_sy, sda_sy, rstn_sy;
	logic       scl_d, sda_d, ext_rst, scl_rise, scl_fall, bus_start, bus_stop;
	logic [tch_pkg::CNT_W-1:0] init_cnt, idle_cnt;
	logic       ready, sleep_req, evt, sda_oe, rw, first, nak, irq;
	tch_pkg::tch_mode_t mode;
	tch_pkg::tch_i2c_t  st;
	logic [3:0] bitcnt;
	logic [7:0] shreg, idx, ctrl, rd_now, rd_next;
	logic [7:0] rep [0:2];
	logic [7:0] irq_cnt;

	// ****************************************
	// pins and reset
	// ****************************************

	assign link.dev_sda_out   = 1'b0;
	assign link.dev_sda_oe    = sda_oe;
	assign link.dev_pullup_en = ctrl[tch_pkg::CTRL_PULLUP];
	assign link.irq           = irq;
	assign mode_out           = mode;
	assign ready_out          = ready;

	// two-flop synchronisers, then one more stage for edges
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			scl_sy  <= 2'b11;
			sda_sy  <= 2'b11;
			rstn_sy <= 2'b00;
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
		end
		else
		begin
			scl_sy  <= {scl_sy[0], link.scl};
			sda_sy  <= {sda_sy[0], link.sda};
			rstn_sy <= {rstn_sy[0], link.rst_n};
			scl_d   <= scl_sy[1];
			sda_d   <= sda_sy[1];
		end

	assign ext_rst   = ~rstn_sy[1];
	assign scl_rise  = scl_sy[1] & ~scl_d;
	assign scl_fall  = ~scl_sy[1] & scl_d;
	assign bus_start = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
	assign bus_stop  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

	// initialisation wait after either reset; bus ignored until done
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			init_cnt <= '0;
			ready    <= 1'b0;
		end
		else if (ext_rst)
		begin
			init_cnt <= '0;
			ready    <= 1'b0;
		end
		else if (!ready)
		begin
			if (init_cnt == tch_pkg::CNT_W'(INIT_CYC - 1))
				ready <= 1'b1;
			else
				init_cnt <= init_cnt + 1'b1;
		end

	// ****************************************
	// working modes
	// ****************************************

	// dynamic to standby on idle, sleep by command, out of sleep by reset only
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			mode        <= tch_pkg::TCH_DYN;
			idle_cnt    <= '0;
			scan_en_out <= 1'b1;
		end
		else if (ext_rst)
		begin
			mode        <= tch_pkg::TCH_DYN;
			idle_cnt    <= '0;
			scan_en_out <= 1'b1;
		end
		else
			case (mode)
				tch_pkg::TCH_DYN:
					if (sleep_req)
					begin
						mode        <= tch_pkg::TCH_SLEEP;
						scan_en_out <= 1'b0;
					end
					else if (touch_valid_in)
						idle_cnt <= '0;
					else if (idle_cnt == tch_pkg::CNT_W'(STANDBY_CYC - 1))
					begin
						if (ctrl[tch_pkg::CTRL_STBY_EN])
						begin
							mode     <= tch_pkg::TCH_STBY;
							idle_cnt <= '0;
						end
					end
					else
						idle_cnt <= idle_cnt + 1'b1;
				tch_pkg::TCH_STBY:
					if (sleep_req)
					begin
						mode        <= tch_pkg::TCH_SLEEP;
						scan_en_out <= 1'b0;
					end
					else if (gesture_in)
						mode <= tch_pkg::TCH_DYN;
				tch_pkg::TCH_SLEEP: mode <= tch_pkg::TCH_SLEEP;
				default:            mode <= tch_pkg::TCH_DYN;
			endcase

	// ****************************************
	// reports and interrupt
	// ****************************************

	assign evt = ready && ((mode == tch_pkg::TCH_DYN && touch_valid_in)
		|| (mode == tch_pkg::TCH_STBY && gesture_in));

	// gesture byte latched with each event; x and y bytes only with dynamic-mode events
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
			for (int i = 0; i < 3; i++)
				rep[i] <= 8'h00;
		else if (ext_rst)
			for (int i = 0; i < 3; i++)
				rep[i] <= 8'h00;
		else if (evt)
		begin
			rep[0] <= gesture_id_in;
			rep[1] <= touch_dyn_x(mode, touch_x_in, rep[1]);
			rep[2] <= touch_dyn_x(mode, touch_y_in, rep[2]);
		end

	function automatic logic [7:0] touch_dyn_x(input tch_pkg::tch_mode_t m,
		input logic [7:0] v, input logic [7:0] old);
		return (m == tch_pkg::TCH_DYN) ? v : old;
	endfunction

	// pulse of fixed width; idle level is the inverse of the active edge
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			irq_cnt <= 8'h00;
			irq     <= 1'b1;
		end
		else if (ext_rst)
		begin
			irq_cnt <= 8'h00;
			irq     <= 1'b1;
		end
		else
		begin
			if (evt)
				irq_cnt <= 8'(tch_pkg::IRQ_PULSE_CYC);
			else if (irq_cnt != 8'h00)
				irq_cnt <= irq_cnt - 8'h01;
			irq <= ~((irq_cnt != 8'h00) ^ ctrl[tch_pkg::CTRL_IRQ_RISE]);
		end

	// ****************************************
	// register access
	// ****************************************

	function automatic logic [7:0] reg_rd(input logic [7:0] a);
		case (a)
			tch_pkg::REG_GEST: return rep[0];
			tch_pkg::REG_X:    return rep[1];
			tch_pkg::REG_Y:    return rep[2];
			tch_pkg::REG_MODE: return {6'h00, mode};
			tch_pkg::REG_CTRL: return ctrl;
			default:           return 8'h00;
		endcase
	endfunction

	assign rd_now  = reg_rd(idx);
	assign rd_next = reg_rd(idx + 8'h01);

	// bus slave: sample on clock rise, drive on clock fall
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			st <= tch_pkg::I_IDLE;
			{bitcnt, shreg, idx, rw, first, nak, sda_oe, sleep_req} <= '0;
			ctrl <= tch_pkg::CTRL_RST;
		end
		else if (ext_rst)
		begin
			st <= tch_pkg::I_IDLE;
			{bitcnt, shreg, idx, rw, first, nak, sda_oe, sleep_req} <= '0;
			ctrl <= tch_pkg::CTRL_RST;
		end
		else
		begin
			sleep_req <= 1'b0;
			if (bus_start)
			begin
				st     <= tch_pkg::I_ADDR;
				bitcnt <= 4'h0;
				sda_oe <= 1'b0;
			end
			else if (bus_stop)
			begin
				st     <= tch_pkg::I_IDLE;
				sda_oe <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (st == tch_pkg::I_ADDR || st == tch_pkg::I_RX)
				begin
					shreg  <= {shreg[6:0], sda_sy[1]};
					bitcnt <= bitcnt + 4'h1;
				end
				else if (st == tch_pkg::I_RACK)
					nak <= sda_sy[1];
			end
			else if (scl_fall)
				case (st)
					tch_pkg::I_ADDR:
						if (bitcnt[3])
						begin
							if (shreg[7:1] == tch_pkg::DEV_ADDR && ready
								&& mode != tch_pkg::TCH_SLEEP)
							begin
								sda_oe <= 1'b1;
								rw     <= shreg[0];
								st     <= tch_pkg::I_AACK;
							end
							else
								st <= tch_pkg::I_IDLE;
						end
					tch_pkg::I_AACK:
						if (rw)
						begin
							shreg  <= rd_now;
							sda_oe <= ~rd_now[7];
							bitcnt <= 4'h1;
							st     <= tch_pkg::I_TX;
						end
						else
						begin
							sda_oe <= 1'b0;
							bitcnt <= 4'h0;
							first  <= 1'b1;
							st     <= tch_pkg::I_RX;
						end
					tch_pkg::I_RX:
						if (bitcnt[3])
						begin
							if (first)
							begin
								idx   <= shreg;
								first <= 1'b0;
							end
							else
							begin
								if (idx == tch_pkg::REG_CTRL)
									ctrl <= shreg;
								if (idx == tch_pkg::REG_CMD && shreg == tch_pkg::SLEEP_CMD)
									sleep_req <= 1'b1;
								idx <= idx + 8'h01;
							end
							sda_oe <= 1'b1;
							st     <= tch_pkg::I_WACK;
						end
					tch_pkg::I_WACK:
					begin
						sda_oe <= 1'b0;
						bitcnt <= 4'h0;
						st     <= tch_pkg::I_RX;
					end
					tch_pkg::I_TX:
						if (bitcnt[3])
						begin
							sda_oe <= 1'b0;
							st     <= tch_pkg::I_RACK;
						end
						else
						begin
							sda_oe <= ~shreg[6];
							shreg  <= {shreg[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					tch_pkg::I_RACK:
						if (nak)
							st <= tch_pkg::I_IDLE;
						else
						begin
							idx    <= idx + 8'h01;
							shreg  <= rd_next;
							sda_oe <= ~rd_next[7];
							bitcnt <= 4'h1;
							st     <= tch_pkg::I_TX;
						end
					default: st <= tch_pkg::I_IDLE;
				endcase
		end
endmodule // tch_dev

// [inc/tch_pkg.sv]
// Purpose: shared constants and types for the touch controller host port
// Assumes: 20 MHz core clock on both ends
// Notes:   counts above 4096 cycles are also top-level parameters
package tch_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ        = 20_000_000;
	localparam int INIT_MS       = 100;
	localparam int INIT_CYC      = INIT_MS * (CLK_HZ / 1_000);
	localparam int PWR_HOLD_MS   = 5;
	localparam int PWR_HOLD_CYC  = PWR_HOLD_MS * (CLK_HZ / 1_000);
	localparam int RST_PULSE_US  = 100;
	localparam int RST_PULSE_CYC = RST_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int STANDBY_S     = 2;
	localparam int STANDBY_CYC   = STANDBY_S * CLK_HZ;
	localparam int IRQ_PULSE_US  = 10;
	localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int SCL_HZ        = 100_000;
	localparam int SCL_Q_CYC     = CLK_HZ / (4 * SCL_HZ);
	localparam int CNT_W         = 26;

	// ****************************************
	// bus addresses and device registers
	// ****************************************
	localparam logic [6:0] DEV_ADDR      = 7'h15;
	localparam logic [7:0] ADDR_WR       = 8'h2A;
	localparam logic [7:0] ADDR_RD       = 8'h2B;
	localparam logic [7:0] REG_GEST      = 8'h00;
	localparam logic [7:0] REG_X         = 8'h01;
	localparam logic [7:0] REG_Y         = 8'h02;
	localparam logic [7:0] REG_MODE      = 8'h03;
	localparam logic [7:0] REG_CTRL      = 8'h04;
	localparam logic [7:0] REG_CMD       = 8'h05;
	localparam logic [7:0] CTRL_RST      = 8'h01;
	localparam int         CTRL_STBY_EN  = 0;
	localparam int         CTRL_IRQ_RISE = 1;
	localparam int         CTRL_PULLUP   = 2;
	localparam logic [7:0] SLEEP_CMD     = 8'h03;

	// ****************************************
	// host command port
	// ****************************************
	localparam logic [2:0] HR_CTRL   = 3'h0;
	localparam logic [2:0] HR_INDEX  = 3'h1;
	localparam logic [2:0] HR_WDATA  = 3'h2;
	localparam logic [2:0] HR_STATUS = 3'h3;
	localparam logic [2:0] HR_RDATA  = 3'h4;
	localparam int         HC_WRITE  = 0;
	localparam int         HC_READ   = 1;
	localparam int         HC_RESET  = 2;
	localparam int         HC_RISE   = 3;
	localparam int         HS_BUSY   = 0;
	localparam int         HS_NAK    = 1;
	localparam int         HS_READY  = 2;
	localparam int         HS_IRQ    = 3;

	typedef enum logic [1:0] {TCH_DYN = 2'b00, TCH_STBY = 2'b01, TCH_SLEEP = 2'b10} tch_mode_t;
	typedef enum logic [2:0] {
		I_IDLE = 3'b000, I_ADDR = 3'b001, I_AACK = 3'b011, I_RX = 3'b010,
		I_WACK = 3'b110, I_TX = 3'b111, I_RACK = 3'b101
	} tch_i2c_t;
	typedef enum logic [1:0] {OP_START = 2'b00, OP_TX = 2'b01, OP_RX = 2'b11, OP_STOP = 2'b10} tch_op_t;

endpackage

// [inc/tch_if.sv]
// Purpose: pins between host and touch controller
// Assumes: open-drain lines pulled high; an undriven reset line reads high
// Notes:   an enable high means that end pulls its line to its out value
`timescale 1ns/1ps
interface tch_if;
	logic scl_out, scl_oe, host_sda_out, host_sda_oe, rst_n_out, rst_n_oe;
	logic dev_sda_out, dev_sda_oe, dev_pullup_en, irq;
	logic scl, sda, rst_n;

	// wired resolution of the shared lines
	assign scl   = ~(scl_oe & ~scl_out);
	assign sda   = ~(host_sda_oe & ~host_sda_out) & ~(dev_sda_oe & ~dev_sda_out);
	assign rst_n = rst_n_oe ? rst_n_out : 1'b1;

	modport dev  (input scl, sda, rst_n, output dev_sda_out, dev_sda_oe, dev_pullup_en, irq);
	modport host (input sda, irq, output scl_out, scl_oe, host_sda_out, host_sda_oe,
		rst_n_out, rst_n_oe);
endinterface

// [verilog/tch_host.sv]
// Purpose: host-side master: reset sequencing, register write and read
// Assumes: 20 MHz core clock, bus run at 100 kHz
// Notes:   one byte per command; read sets the index then repeated start
`timescale 1ns/1ps
module tch_host #(
	parameter int PWR_HOLD_CYC = tch_pkg::PWR_HOLD_CYC,
	parameter int INIT_CYC     = tch_pkg::INIT_CYC
) (
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	tch_if.host             link
);
	logic [1:0] sda_sy, irq_sy;
	logic       irq_d, rise_sel, irq_seen, nak, busy, ready, rst_drive, pwr_phase;
	logic [7:0] index, wdata, rbyte, txbyte, status;
	logic [tch_pkg::CNT_W-1:0] rcnt;
	logic [5:0] qcnt;
	logic [1:0] q;
	logic [2:0] seq;
	logic [3:0] bitn;
	logic       rd_op, scl_oe, sda_oe, tick, go, irq_edge;
	tch_pkg::tch_op_t op;

	assign link.scl_out      = 1'b0;
	assign link.host_sda_out = 1'b0;
	assign link.rst_n_out    = 1'b0;
	assign link.scl_oe       = scl_oe;
	assign link.host_sda_oe  = sda_oe;
	assign link.rst_n_oe     = rst_drive;

	// two-flop synchronisers for pins and edge history
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			sda_sy <= 2'b11;
			irq_sy <= 2'b11; // idle level of the falling default, no false edge
			irq_d  <= 1'b1;
		end
		else
		begin
			sda_sy <= {sda_sy[0], link.sda};
			irq_sy <= {irq_sy[0], link.irq};
			irq_d  <= irq_sy[1];
		end

	// power-up hold, reset pulse and init wait
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			rst_drive <= 1'b1;
			pwr_phase <= 1'b1;
			ready     <= 1'b0;
			rcnt      <= '0;
		end
		else if (rst_drive)
		begin
			if (rcnt == tch_pkg::CNT_W'(pwr_phase ? PWR_HOLD_CYC - 1 : tch_pkg::RST_PULSE_CYC - 1))
			begin
				rst_drive <= 1'b0;
				rcnt      <= '0;
			end
			else
				rcnt <= rcnt + 1'b1;
		end
		else if (!ready)
		begin
			if (rcnt == tch_pkg::CNT_W'(INIT_CYC - 1))
				ready <= 1'b1;
			else
				rcnt <= rcnt + 1'b1;
		end
		else if (wr_in && addr_in == tch_pkg::HR_CTRL && wdata_in[tch_pkg::HC_RESET] && !busy)
		begin
			rst_drive <= 1'b1;
			pwr_phase <= 1'b0;
			ready     <= 1'b0;
			rcnt      <= '0;
		end

	// command registers and sticky interrupt flag, set beats clear
	assign irq_edge = rise_sel ? (irq_sy[1] & ~irq_d) : (~irq_sy[1] & irq_d);
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			index    <= 8'h00;
			wdata    <= 8'h00;
			rise_sel <= 1'b0;
			irq_seen <= 1'b0;
		end
		else
		begin
			if (wr_in && addr_in == tch_pkg::HR_INDEX)
				index <= wdata_in;
			if (wr_in && addr_in == tch_pkg::HR_WDATA)
				wdata <= wdata_in;
			if (wr_in && addr_in == tch_pkg::HR_CTRL)
				rise_sel <= wdata_in[tch_pkg::HC_RISE];
			if (irq_edge)
				irq_seen <= 1'b1;
			else if (wr_in && addr_in == tch_pkg::HR_STATUS && wdata_in[tch_pkg::HS_IRQ])
				irq_seen <= 1'b0;
		end

	// status word and read port
	always_comb
	begin
		status = 8'h00;
		status[tch_pkg::HS_BUSY]  = busy;
		status[tch_pkg::HS_NAK]   = nak;
		status[tch_pkg::HS_READY] = ready;
		status[tch_pkg::HS_IRQ]   = irq_seen;
	end
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
			rdata_out <= 8'h00;
		else if (rd_in)
			case (addr_in)
				tch_pkg::HR_INDEX:  rdata_out <= index;
				tch_pkg::HR_WDATA:  rdata_out <= wdata;
				tch_pkg::HR_STATUS: rdata_out <= status;
				tch_pkg::HR_RDATA:  rdata_out <= rbyte;
				default:            rdata_out <= 8'h00;
			endcase
		else
			rdata_out <= 8'h00;

	// transfer program: write index then data, or index, restart, read
	always_comb
	begin
		op     = tch_pkg::OP_STOP;
		txbyte = tch_pkg::ADDR_WR;
		case (seq)
			3'd0:    op = tch_pkg::OP_START;
			3'd1:    op = tch_pkg::OP_TX;
			3'd2:
			begin
				op     = tch_pkg::OP_TX;
				txbyte = index;
			end
			3'd3:
			begin
				op     = rd_op ? tch_pkg::OP_START : tch_pkg::OP_TX;
				txbyte = wdata;
			end
			3'd4:
			begin
				op     = rd_op ? tch_pkg::OP_TX : tch_pkg::OP_STOP;
				txbyte = tch_pkg::ADDR_RD;
			end
			3'd5:    op = tch_pkg::OP_RX;
			default: op = tch_pkg::OP_STOP;
		endcase
	end

	assign go   = wr_in && addr_in == tch_pkg::HR_CTRL && ready && !busy && !rst_drive
		&& (wdata_in[tch_pkg::HC_WRITE] || wdata_in[tch_pkg::HC_READ]);
	assign tick = busy && qcnt == 6'(tch_pkg::SCL_Q_CYC - 1);

	// quarter-bit divider for the bus clock
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
			qcnt <= 6'h00;
		else if (!busy || tick)
			qcnt <= 6'h00;
		else
			qcnt <= qcnt + 6'h01;

	// bit engine, four quarters per bit
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
		begin
			busy   <= 1'b0;
			rd_op  <= 1'b0;
			nak    <= 1'b0;
			rbyte  <= 8'h00;
			seq    <= 3'd0;
			bitn   <= 4'h0;
			q      <= 2'd0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (go)
		begin
			busy  <= 1'b1;
			rd_op <= wdata_in[tch_pkg::HC_READ];
			nak   <= 1'b0;
			seq   <= 3'd0;
			bitn  <= 4'h0;
			q     <= 2'd0;
		end
		else if (tick)
		begin
			q <= q + 2'd1;
			case (q)
				2'd0:
					case (op)
						tch_pkg::OP_START: sda_oe <= 1'b0;
						tch_pkg::OP_STOP:  sda_oe <= 1'b1;
						tch_pkg::OP_TX:    sda_oe <= bitn[3] ? 1'b0 : ~txbyte[3'(4'h7 - bitn)];
						default:           sda_oe <= 1'b0; // read bits and final no-acknowledge
					endcase
				2'd1: scl_oe <= 1'b0;
				2'd2:
					case (op)
						tch_pkg::OP_START: sda_oe <= 1'b1;
						tch_pkg::OP_STOP:  sda_oe <= 1'b0;
						tch_pkg::OP_TX:    if (bitn[3]) nak <= nak | sda_sy[1];
						default:           if (!bitn[3]) rbyte <= {rbyte[6:0], sda_sy[1]};
					endcase
				default:
					if (op == tch_pkg::OP_STOP)
						busy <= 1'b0;
					else
					begin
						scl_oe <= 1'b1;
						if (op == tch_pkg::OP_START || bitn[3])
						begin
							seq  <= seq + 3'd1;
							bitn <= 4'h0;
						end
						else
							bitn <= bitn + 4'h1;
					end
			endcase
		end
endmodule // tch_host

// [testbench/tch_props.sv]
// Purpose: link checks between the host and touch controller ends
// Assumes: 20 MHz core clock; lines already resolved by tch_if
// Notes:   counts are saturating helper registers
`timescale 1ns/1ps
module tch_props #(
	parameter int PULSE_MIN = 2000
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic rst_n,
	input wire logic irq,
	input wire logic dev_sda_oe,
	input wire logic host_sda_oe
);
	logic        scl_q;
	logic [11:0] run;
	logic [15:0] lo;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	// ****************************************
	// helper counters
	// ****************************************
	// cycles since scl last moved
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			run <= '0;
		else if (scl != scl_q)
			run <= '0;
		else if (run != '1)
			run <= run + 12'h001;
	end
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			scl_q <= 1'b1;
		else
			scl_q <= scl;
	end
	// cycles the reset line has been held low
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			lo <= '0;
		else if (rst_n)
			lo <= '0;
		else if (lo != '1)
			lo <= lo + 16'h0001;
	end

	// ****************************************
	// properties
	// ****************************************
	property p_scl_low; $rose(scl) |-> run >= 12'd26 && run <= 12'd2000; endproperty
	a_scl_low: assert property (p_scl_low)
		else $error("scl low time out of range");
	property p_scl_high; $fell(scl) |-> run >= 12'd12; endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("scl high time too short");
	property p_rst_low; $rose(rst_n) |-> lo >= PULSE_MIN; endproperty
	a_rst_low: assert property (p_rst_low)
		else $error("reset pulse too short");
	property p_reset_all; !rst_n [*4] |-> !dev_sda_oe && irq; endproperty
	a_reset_all: assert property (p_reset_all)
		else $error("device active while reset held");
	property p_dev_hold; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("device data bit not held");
	property p_dev_on_low; $changed(dev_sda_oe) |-> !scl; endproperty
	a_dev_on_low: assert property (p_dev_on_low)
		else $error("device moved sda while scl high");
	property p_host_frame;
		scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe);
	endproperty
	a_host_frame: assert property (p_host_frame)
		else $error("start or stop not made by host");
	property p_irq_idle; $fell(rst_in) |-> irq; endproperty
	a_irq_idle: assert property (p_irq_idle)
		else $error("interrupt not idle after reset");
endmodule // tch_props

// [testbench/tb_top.sv]
// Purpose: bench joining host and touch controller ends
// Assumes: shortened init, standby and power hold counts
// Notes:   random values from an xorshift generator
`timescale 1ns/1ps
module tb_top;
	localparam int INIT = 2000;
	localparam int PWR  = 2000;
	localparam int STBY = 12000;
	logic        core_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [2:0]  addr_in = 3'h0;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [7:0]  rdata_out;
	logic        touch_valid_in = 1'b0;
	logic [7:0]  touch_x_in = 8'h00;
	logic [7:0]  touch_y_in = 8'h00;
	logic        gesture_in = 1'b0;
	logic [7:0]  gesture_id_in = 8'h00;
	logic [1:0]  mode_out;
	logic        scan_en_out;
	logic        ready_out;
	logic [31:0] seed = 32'h968C065D;
	logic [7:0]  d;
	logic [7:0]  ctl;
	int          miscompares = 0;
	int          compares = 0;
	int          n;

	tch_if link_if ();
	tch_host #(.PWR_HOLD_CYC(PWR), .INIT_CYC(INIT)) tch_host_inst (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .link(link_if));
	tch_dev #(.INIT_CYC(INIT), .STANDBY_CYC(STBY)) tch_dev_inst (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .touch_valid_in(touch_valid_in), .touch_x_in(touch_x_in),
		.touch_y_in(touch_y_in), .gesture_in(gesture_in), .gesture_id_in(gesture_id_in),
		.mode_out(mode_out), .scan_en_out(scan_en_out), .ready_out(ready_out), .link(link_if));
	tch_props #(.PULSE_MIN(PWR)) tch_props_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.scl(link_if.scl), .sda(link_if.sda), .rst_n(link_if.rst_n), .irq(link_if.irq),
		.dev_sda_oe(link_if.dev_sda_oe), .host_sda_oe(link_if.host_sda_oe));

	// 20 MHz clock
	always #25 core_clk_in = ~core_clk_in;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic summarize();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge core_clk_in);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	// bounded poll of one status bit; running out ends the run
	task automatic wait_st(input int b, input logic v);
		logic [7:0] s;
		for (int i = 0; i < 15000; i++)
		begin
			rd(tch_pkg::HR_STATUS, s);
			if (s[b] === v)
				return;
		end
		chk(32'h0, 32'h1);
		summarize();
	endtask
	task automatic dev_wr(input logic [7:0] idx, input logic [7:0] v);
		wr(tch_pkg::HR_INDEX, idx);
		wr(tch_pkg::HR_WDATA, v);
		wr(tch_pkg::HR_CTRL, 8'h01 << tch_pkg::HC_WRITE);
		wait_st(tch_pkg::HS_BUSY, 1'b0);
	endtask
	task automatic dev_rd(input logic [7:0] idx, output logic [7:0] v);
		wr(tch_pkg::HR_INDEX, idx);
		wr(tch_pkg::HR_CTRL, 8'h01 << tch_pkg::HC_READ);
		wait_st(tch_pkg::HS_BUSY, 1'b0);
		rd(tch_pkg::HR_RDATA, v);
	endtask
	// time from reset line release to device ready
	task automatic chk_init();
		for (n = 0; link_if.rst_n !== 1'b0 && n < 9000; n++)
			tick();
		for (n = 0; link_if.rst_n !== 1'b1 && n < 9000; n++)
			tick();
		for (n = 0; ready_out !== 1'b1 && n < 9000; n++)
			tick();
		chk(n >= INIT && n <= INIT + 4, 1'b1);
		wait_st(tch_pkg::HS_READY, 1'b1);
	endtask
	// one touch or gesture event with random report bytes
	task automatic pulse(input logic g);
		@(posedge core_clk_in);
		seed = xs(seed);
		touch_x_in <= seed[7:0];
		touch_y_in <= seed[15:8];
		gesture_id_in <= seed[23:16];
		touch_valid_in <= !g;
		gesture_in <= g;
		@(posedge core_clk_in);
		touch_valid_in <= 1'b0;
		gesture_in <= 1'b0;
	endtask
	task automatic chk_irq(input logic act);
		for (int i = 0; i < 4 && link_if.irq !== act; i++)
			tick();
		for (n = 0; link_if.irq === act && n < 300; n++)
			tick();
		chk(n, tch_pkg::IRQ_PULSE_CYC);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (20) @(posedge core_clk_in);
		rst_in <= 1'b0;
		rd(tch_pkg::HR_STATUS, d);
		chk(d[tch_pkg::HS_READY], 1'b0);
		chk_init();
		seed = xs(seed);
		ctl = {5'h00, seed[2], 2'b11};
		dev_wr(tch_pkg::REG_CTRL, ctl);
		rd(tch_pkg::HR_STATUS, d);
		chk(d[tch_pkg::HS_NAK], 1'b0);
		chk(link_if.dev_pullup_en, ctl[2]);
		chk(link_if.irq, 1'b0);
		wr(tch_pkg::HR_CTRL, 8'h01 << tch_pkg::HC_RISE);
		wr(tch_pkg::HR_STATUS, 8'h01 << tch_pkg::HS_IRQ);
		rd(tch_pkg::HR_STATUS, d);
		chk(d[tch_pkg::HS_IRQ], 1'b0);
		pulse(1'b0);
		chk_irq(1'b1);
		rd(tch_pkg::HR_STATUS, d);
		chk(d[tch_pkg::HS_IRQ], 1'b1);
		dev_rd(tch_pkg::REG_X, d);
		chk(d, touch_x_in);
		dev_rd(tch_pkg::REG_Y, d);
		chk(d, touch_y_in);
		// standby falls due one idle period after the touch
		for (n = 0; mode_out !== tch_pkg::TCH_STBY && n < STBY; n++)
			tick();
		chk(mode_out, tch_pkg::TCH_STBY);
		pulse(1'b1);
		chk_irq(1'b1);
		chk(mode_out, tch_pkg::TCH_DYN);
		dev_wr(tch_pkg::REG_CTRL, ctl & 8'hFE);
		dev_rd(tch_pkg::REG_GEST, d);
		chk(d, gesture_id_in);
		repeat (3010) tick();
		chk(mode_out, tch_pkg::TCH_DYN);
		dev_wr(tch_pkg::REG_CMD, tch_pkg::SLEEP_CMD);
		chk({scan_en_out, mode_out}, {1'b0, tch_pkg::TCH_SLEEP});
		pulse(1'b0);
		n = 0;
		repeat (250)
		begin
			tick();
			n += (link_if.irq !== 1'b0);
		end
		chk(n, 0);
		dev_wr(tch_pkg::REG_CTRL, 8'h01);
		rd(tch_pkg::HR_STATUS, d);
		chk(d[tch_pkg::HS_NAK], 1'b1);
		wr(tch_pkg::HR_CTRL, 8'h01 << tch_pkg::HC_RESET);
		chk_init();
		chk(mode_out, tch_pkg::TCH_DYN);
		dev_rd(tch_pkg::REG_CTRL, d);
		chk(d, tch_pkg::CTRL_RST);
		pulse(1'b0);
		chk_irq(1'b0);
		rd(3'h5, d);
		chk(d, 8'h00);
		summarize();
	end
endmodule // tb_top
